// *** core/acs_regs.vh ***
// Purpose: constants for the asynchronous base-clock select block
// Assumes: included by bare name from core/ design files
// Notes:   definitions only
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ACS_OFF_EXT5      8'h00
`define ACS_OFF_EXT6      8'h04
`define ACS_OFF_MODE5     8'h08
`define ACS_OFF_MODE6     8'h0C
`define ACS_OFF_DIV5      8'h10
`define ACS_OFF_DIV6      8'h14
`define ACS_OFF_AVG5      8'h18
`define ACS_OFF_AVG6      8'h1C
`define ACS_OFF_STAT      8'h20

// ****************************************************************
// extended mode register fields
// ****************************************************************
`define ACS_EXT_RATIO_BIT 4
`define ACS_EXT_SRC_MSB   3
`define ACS_EXT_SRC_LSB   0
`define ACS_EXT_WMASK     8'h1F
`define ACS_EXT_RESET     8'h00

// ****************************************************************
// serial mode / control bits
// ****************************************************************
`define ACS_MODE_SYNC_BIT  0
`define ACS_MODE_EXTCK_BIT 1
`define ACS_MODE_WMASK     8'h03
`define ACS_MODE_RESET     8'h00
`define ACS_DIV_RESET      16'h0000
`define ACS_AVG_RESET      16'h0000

// ****************************************************************
// clock source codes
// ****************************************************************
`define ACS_SRC_INTERNAL  4'h0
`define ACS_SRC_TMR2      4'h1
`define ACS_SRC_TMR3      4'h2
`define ACS_SRC_AVG_BIT   3

// ****************************************************************
// oversampling counts
// ****************************************************************
`define ACS_OVS_16        5'h10
`define ACS_OVS_8         5'h08

// ****************************************************************
// peripheral clock rates that allow averaging (kHz)
// ****************************************************************
`define ACS_AVG_KHZ_0     8000
`define ACS_AVG_KHZ_1     10667
`define ACS_AVG_KHZ_2     12000
`define ACS_AVG_KHZ_3     16000
`define ACS_AVG_KHZ_4     24000
`define ACS_AVG_KHZ_5     32000

// ****************************************************************
// status register fields
// ****************************************************************
`define ACS_STAT_FOK_BIT  0
`define ACS_STAT_AVG_LSB  1
`define ACS_STAT_TMR_LSB  3
`define ACS_STAT_X8_LSB   5

`endif

// *** core/acs_baud_div.v ***
// Purpose: counts input ticks and pulses once per period
// Assumes: period of zero is treated as one
// Notes:   tick_out is a registered one-cycle pulse
`timescale 1ns/1ns
`default_nettype none

module acs_baud_div #(
  parameter W = 16
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // control
  input  wire         en,
  input  wire         tick_in,
  input  wire [W-1:0] period,
  // result
  output reg          tick_out
);

  reg [W-1:0] cnt_q;
  wire        last;

  assign last = (period == {W{1'b0}}) || (cnt_q >= period - {{(W-1){1'b0}}, 1'b1});

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q    <= {W{1'b0}};
      tick_out <= 1'b0;
    end
    else if (!en)
    begin
      cnt_q    <= {W{1'b0}};
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= tick_in & last;
      if (tick_in)
      begin
        if (last)
          cnt_q <= {W{1'b0}};
        else
          cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // acs_baud_div

`default_nettype wire

// *** core/acs_avg_gen.v ***
// Purpose: average-rate base tick by phase accumulation
// Assumes: inc sets the mean tick rate as inc/2^W of pclk
// Notes:   ticks are spread so the average rate is exact
`timescale 1ns/1ns
`default_nettype none

module acs_avg_gen #(
  parameter W = 16
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // control
  input  wire         en,
  input  wire [W-1:0] inc,
  // result
  output reg          tick
);

  reg  [W-1:0] acc_q;
  wire [W:0]   sum;

  assign sum = {1'b0, acc_q} + {1'b0, inc};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q <= {W{1'b0}};
      tick  <= 1'b0;
    end
    else if (!en)
    begin
      acc_q <= {W{1'b0}};
      tick  <= 1'b0;
    end
    else
    begin
      acc_q <= sum[W-1:0];
      tick  <= sum[W];
    end
  end

endmodule // acs_avg_gen

`default_nettype wire

// *** core/acs_top.v ***
// Purpose: base-clock source select for serial channels five and six
// Assumes: APB slave, zero wait states, pclk at 25 MHz
// Notes:   index 0 of each vector is channel five, index 1 channel six
`timescale 1ns/1ns
`default_nettype none
`include "acs_regs.vh"

module acs_top #(
  parameter PCLK_KHZ = 25000,
  parameter DIV_W    = 16,
  parameter AVG_W    = 16
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // timer compare outputs
  input  wire        tmr2_cmp_out,
  input  wire        tmr3_cmp_out,
  // base clock results per channel
  output wire [1:0]  base_tick,
  output wire [1:0]  bit_tick,
  output reg  [1:0]  over_x8,
  output reg  [1:0]  avg_active
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function freq_ok;
    input integer khz;
    begin
      freq_ok = (khz == `ACS_AVG_KHZ_0) || (khz == `ACS_AVG_KHZ_1) ||
                (khz == `ACS_AVG_KHZ_2) || (khz == `ACS_AVG_KHZ_3) ||
                (khz == `ACS_AVG_KHZ_4) || (khz == `ACS_AVG_KHZ_5);
    end
  endfunction

  function [4:0] ovs_count;
    input ratio_bit;
    begin
      ovs_count = ratio_bit ? `ACS_OVS_8 : `ACS_OVS_16;
    end
  endfunction

  function [31:0] pad8;
    input [7:0] v;
    begin
      pad8 = {24'h000000, v};
    end
  endfunction

  function [31:0] pad16;
    input [15:0] v;
    begin
      pad16 = {16'h0000, v};
    end
  endfunction

  localparam AVG_ALLOWED = freq_ok(PCLK_KHZ);

  // ****************************************************************
  // register storage
  // ****************************************************************
  reg [7:0]       ext_q  [0:1];
  reg [7:0]       mode_q [0:1];
  reg [DIV_W-1:0] div_q  [0:1];
  reg [AVG_W-1:0] avg_q  [0:1];
  reg             tmr2_q;
  reg             tmr3_q;

  wire setup    = psel & ~penable;
  wire wr_fire  = psel & penable & pwrite;
  wire tmr2_rise = tmr2_cmp_out & ~tmr2_q;
  wire tmr3_rise = tmr3_cmp_out & ~tmr3_q;

  assign pready = 1'b1;

  // ****************************************************************
  // register writes
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_q[0]  <= `ACS_EXT_RESET;
      ext_q[1]  <= `ACS_EXT_RESET;
      mode_q[0] <= `ACS_MODE_RESET;
      mode_q[1] <= `ACS_MODE_RESET;
      div_q[0]  <= `ACS_DIV_RESET;
      div_q[1]  <= `ACS_DIV_RESET;
      avg_q[0]  <= `ACS_AVG_RESET;
      avg_q[1]  <= `ACS_AVG_RESET;
    end
    else if (wr_fire)
    begin
      case (paddr)
        // reserved top bits are not writable
        `ACS_OFF_EXT5:  ext_q[0]  <= pwdata[7:0] & `ACS_EXT_WMASK;
        `ACS_OFF_EXT6:  ext_q[1]  <= pwdata[7:0] & `ACS_EXT_WMASK;
        `ACS_OFF_MODE5: mode_q[0] <= pwdata[7:0] & `ACS_MODE_WMASK;
        `ACS_OFF_MODE6: mode_q[1] <= pwdata[7:0] & `ACS_MODE_WMASK;
        `ACS_OFF_DIV5:  div_q[0]  <= pwdata[DIV_W-1:0];
        `ACS_OFF_DIV6:  div_q[1]  <= pwdata[DIV_W-1:0];
        `ACS_OFF_AVG5:  avg_q[0]  <= pwdata[AVG_W-1:0];
        `ACS_OFF_AVG6:  avg_q[1]  <= pwdata[AVG_W-1:0];
        default:
        begin
        end
      endcase
    end
  end

  // ****************************************************************
  // timer edge capture
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tmr2_q <= 1'b0;
      tmr3_q <= 1'b0;
    end
    else
    begin
      tmr2_q <= tmr2_cmp_out;
      tmr3_q <= tmr3_cmp_out;
    end
  end

  // ****************************************************************
  // per-channel source selection
  // ****************************************************************
  wire [1:0] async_mode;
  wire [1:0] sel_avg;
  wire [1:0] sel_tmr;
  wire [1:0] int_tick;
  wire [1:0] avg_tick;
  reg  [1:0] base_mux;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_ch
      wire [3:0] src = ext_q[ch][`ACS_EXT_SRC_MSB:`ACS_EXT_SRC_LSB];
      wire       ratio_eff;
      wire [4:0] ovs;

      // settings only act in asynchronous mode
      assign async_mode[ch] = ~mode_q[ch][`ACS_MODE_SYNC_BIT];
      // field is trusted to be set with external clock selected
      assign sel_avg[ch] = async_mode[ch] & src[`ACS_SRC_AVG_BIT] &
                           AVG_ALLOWED[0];
      assign sel_tmr[ch] = async_mode[ch] & ~src[`ACS_SRC_AVG_BIT] &
                           ((src == `ACS_SRC_TMR2) || (src == `ACS_SRC_TMR3));
      // averaging fixes the ratio at 16x whatever the bit says
      assign ratio_eff = sel_avg[ch] ? 1'b0 : ext_q[ch][`ACS_EXT_RATIO_BIT];
      assign ovs = ovs_count(ratio_eff);

      acs_baud_div #(
        .W        (DIV_W)
      ) u_int_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .en       (~sel_avg[ch] & ~sel_tmr[ch]),
        .tick_in  (1'b1),
        .period   (div_q[ch]),
        .tick_out (int_tick[ch])
      );

      acs_avg_gen #(
        .W        (AVG_W)
      ) u_avg (
        .pclk     (pclk),
        .presetn  (presetn),
        .en       (sel_avg[ch]),
        .inc      (avg_q[ch]),
        .tick     (avg_tick[ch])
      );

      acs_baud_div #(
        .W        (5)
      ) u_bit_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .en       (async_mode[ch]),
        .tick_in  (base_mux[ch]),
        .period   (ovs),
        .tick_out (bit_tick[ch])
      );

      always @*
      begin
        base_mux[ch] = int_tick[ch];
        if (sel_avg[ch])
          base_mux[ch] = avg_tick[ch];
        else if (sel_tmr[ch])
          base_mux[ch] = (src == `ACS_SRC_TMR2) ? tmr2_rise : tmr3_rise;
      end

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          over_x8[ch]    <= 1'b0;
          avg_active[ch] <= 1'b0;
        end
        else
        begin
          over_x8[ch]    <= async_mode[ch] & ratio_eff;
          avg_active[ch] <= sel_avg[ch];
        end
      end
    end
  endgenerate

  assign base_tick = base_mux;

  // ****************************************************************
  // read path
  // ****************************************************************
  reg [31:0] rd_d;
  reg        err_d;

  always @*
  begin
    rd_d  = 32'h00000000;
    err_d = 1'b0;
    case (paddr)
      `ACS_OFF_EXT5:  rd_d = pad8(ext_q[0]);
      `ACS_OFF_EXT6:  rd_d = pad8(ext_q[1]);
      `ACS_OFF_MODE5: rd_d = pad8(mode_q[0]);
      `ACS_OFF_MODE6: rd_d = pad8(mode_q[1]);
      `ACS_OFF_DIV5:  rd_d = pad16(div_q[0]);
      `ACS_OFF_DIV6:  rd_d = pad16(div_q[1]);
      `ACS_OFF_AVG5:  rd_d = pad16(avg_q[0]);
      `ACS_OFF_AVG6:  rd_d = pad16(avg_q[1]);
      `ACS_OFF_STAT:
      begin
        rd_d[`ACS_STAT_FOK_BIT]         = AVG_ALLOWED[0];
        rd_d[`ACS_STAT_AVG_LSB+1:`ACS_STAT_AVG_LSB] = avg_active;
        rd_d[`ACS_STAT_TMR_LSB+1:`ACS_STAT_TMR_LSB] = sel_tmr;
        rd_d[`ACS_STAT_X8_LSB+1:`ACS_STAT_X8_LSB]   = over_x8;
      end
      default:
        err_d = 1'b1;
    endcase
  end

  // data captured in setup so access phase completes at once
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? 32'h00000000 : rd_d;
      pslverr <= err_d;
    end
    else if (!psel)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

endmodule // acs_top

`default_nettype wire

// *** test/acs_chk.sv ***
// Purpose: bus and clock-select checks on acs_top
// Assumes: channel five settings mirrored from bus writes
// Notes:   bind follows the module
`timescale 1ns/1ns
`default_nettype none
module acs_chk #(
  parameter PCLK_KHZ = 25000
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        tmr2_cmp_out,
  input wire logic        tmr3_cmp_out,
  input wire logic [1:0]  base_tick,
  input wire logic [1:0]  bit_tick,
  input wire logic [1:0]  over_x8,
  input wire logic [1:0]  avg_active
);
  logic [4:0] ext_q;
  logic       sync_q;
  logic       um;
  logic       alw;
  logic       avg_e;
  logic       x8_e;
  assign um    = (paddr[1:0] != 2'h0) || (paddr > 8'h20);
  assign alw   = PCLK_KHZ == 8000 || PCLK_KHZ == 10667 || PCLK_KHZ == 12000 ||
                 PCLK_KHZ == 16000 || PCLK_KHZ == 24000 || PCLK_KHZ == 32000;
  assign avg_e = !sync_q && ext_q[3] && alw;
  assign x8_e  = !sync_q && ext_q[4] && !avg_e;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_q  <= 5'h00;
      sync_q <= 1'b0;
    end
    else if (psel && penable && pwrite && paddr == 8'h00)
      ext_q  <= pwdata[4:0];
    else if (psel && penable && pwrite && paddr == 8'h08)
      sync_q <= pwdata[0];
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rd_ext;
    psel && !penable && !pwrite && paddr == 8'h00;
  endsequence
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (s_setup ##0 um |=> pslverr)
    else $error("no error on unmapped access");
  a_mapped_ok: assert property (s_setup ##0 !um |=> !pslverr)
    else $error("error on mapped access");
  a_ext_readback: assert property (s_rd_ext |=> prdata == {27'h0, ext_q})
    else $error("extended mode readback wrong");
  a_ratio_x8: assert property (over_x8[0] == $past(x8_e))
    else $error("over_x8 wrong");
  a_avg_active: assert property (avg_active[0] == $past(avg_e))
    else $error("avg_active wrong");
  a_timer_tick: assert property (!sync_q && ext_q[3:0] == 4'h1 && $stable(ext_q)
    |-> base_tick[0] == $rose(tmr2_cmp_out))
    else $error("timer base tick wrong");
  a_sync_quiet: assert property (sync_q && $stable(sync_q) |-> !bit_tick[0])
    else $error("bit tick in sync mode");
endmodule // acs_chk
bind acs_top acs_chk #(.PCLK_KHZ(PCLK_KHZ)) u_acs_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .tmr2_cmp_out(tmr2_cmp_out), .tmr3_cmp_out(tmr3_cmp_out), .base_tick(base_tick),
  .bit_tick(bit_tick), .over_x8(over_x8), .avg_active(avg_active)
);
`default_nettype wire

// *** test/acs_top_tb.sv ***
// Purpose: directed register and tick tests for acs_top
// Assumes: 16 MHz rate parameter so averaging is allowed
// Notes:   ticks counted by a sampling monitor
`timescale 1ns/1ns
`default_nettype none
module acs_top_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        tmr2_cmp_out;
  logic        tmr3_cmp_out;
  wire         pready;
  wire  [31:0] prdata;
  wire         pslverr;
  wire  [1:0]  base_tick;
  wire  [1:0]  bit_tick;
  wire  [1:0]  over_x8;
  wire  [1:0]  avg_active;
  logic [31:0] rd_q;
  logic        err_q;
  logic [7:0]  bad [3] = '{8'h24, 8'h02, 8'hFC};
  int          fail_count;
  int          n_compared;
  int          bt [2];
  int          bi [2];
  acs_top #(.PCLK_KHZ(16000)) u_acs_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .tmr2_cmp_out(tmr2_cmp_out),
    .tmr3_cmp_out(tmr3_cmp_out), .base_tick(base_tick), .bit_tick(bit_tick),
    .over_x8(over_x8), .avg_active(avg_active)
  );
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (base_tick[i] === 1'b1) bt[i]++;
      if (bit_tick[i] === 1'b1) bi[i]++;
    end
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(nm, e, rd_q);
  endtask
  task automatic pulse(input int n);
    repeat (n)
    begin
      tmr2_cmp_out <= 1'b1;
      tmr3_cmp_out <= 1'b1;
      @(posedge pclk);
      tmr2_cmp_out <= 1'b0;
      tmr3_cmp_out <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic clr;
    bt = '{0, 0};
    bi = '{0, 0};
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #2000000;
    fail_count++;
    give_verdict();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    {presetn, psel, penable, pwrite, tmr2_cmp_out, tmr3_cmp_out} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 8; a++)
      rchk("reset value", 8'(4 * a), 32'h0);
    rchk("status rate ok", 8'h20, 32'h1);
    acc(1'b1, 8'h08, 32'h02);
    acc(1'b1, 8'h0C, 32'h02);
    acc(1'b1, 8'h00, 32'hFFFF_FFFF);
    rchk("ext five mask", 8'h00, 32'h1F);
    rchk("ext six apart", 8'h04, 32'h0);
    chk("avg flags", 32'h1, {30'h0, avg_active});
    chk("avg ignores ratio", 32'h0, {30'h0, over_x8});
    rchk("status avg", 8'h20, 32'h3);
    foreach (bad[i])
    begin
      acc(1'b1, bad[i], 32'h1F);
      chk("write error", 32'h1, {31'h0, err_q});
      rchk("unmapped read", bad[i], 32'h0);
      chk("read error", 32'h1, {31'h0, err_q});
    end
    acc(1'b1, 8'h00, 32'h11);
    acc(1'b1, 8'h04, 32'h02);
    chk("x8 flags", 32'h1, {30'h0, over_x8});
    rchk("status timer", 8'h20, 32'h39);
    // status is read only: write ignored without error
    acc(1'b1, 8'h20, 32'hFF);
    chk("status write error", 32'h0, {31'h0, err_q});
    rchk("status kept", 8'h20, 32'h39);
    clr();
    pulse(32);
    // let the last registered bit tick reach the monitor
    @(posedge pclk);
    chk("ch5 base ticks", 32, bt[0]);
    chk("ch6 base ticks", 32, bt[1]);
    chk("ch5 bit ticks", 4, bi[0]);
    chk("ch6 bit ticks", 2, bi[1]);
    acc(1'b1, 8'h08, 32'hFF);
    rchk("mode bits", 8'h08, 32'h3);
    chk("sync x8 off", 32'h0, {31'h0, over_x8[0]});
    clr();
    pulse(16);
    @(posedge pclk);
    chk("sync bit ticks", 0, bi[0]);
    acc(1'b1, 8'h08, 32'h02);
    acc(1'b1, 8'h18, 32'h8000);
    acc(1'b1, 8'h00, 32'h18);
    clr();
    repeat (256) @(posedge pclk);
    chk("avg base ticks", 1, 32'(bt[0] inside {[126:130]}));
    chk("avg bit ticks", 1, 32'(bi[0] inside {[7:9]}));
    // internal divider: period of four pclk, first tick seen five edges after select
    acc(1'b1, 8'h10, 32'h4);
    rchk("divider readback", 8'h10, 32'h4);
    acc(1'b1, 8'h00, 32'h00);
    clr();
    repeat (198) @(posedge pclk);
    chk("internal base ticks", 32'h31, bt[0]);
    chk("internal no avg", 32'h0, {30'h0, avg_active});
    give_verdict();
  end
endmodule // acs_top_tb
`default_nettype wire
